/* hw/osc_freq_control_regs.sv */
// Frequency pull, pull range and feedback divider registers of
// the programmable oscillator, written by the serial port engine.
// Assumes one-cycle word strobes synchronous to clock.
//
// Behaviour
// RULE1 - Upper pull register bits 15:11 read as zero, writes to them ignored.
// RULE2 - Bit 10 is software output enable, 1 enables, resets to 0.
// RULE3 - Software enable acts only in software mode; pin mode ignores the bit.
// RULE4 - Bits 9:0 hold upper ten bits of the 26-bit pull word.
// RULE5 - Register 0x00 holds bits 15:0 of the pull word.
// RULE6 - All pull word bits reset to zero, meaning nominal frequency.
// RULE7 - The combined pull word is signed two's complement.
// RULE8 - Only an upper word write starts a pull change; lower alone does not.
// RULE9 - Host should write lower word before upper word.
// RULE10 - Range register bits 15:4 read as zero, writes ignored.
// RULE11 - Range bits 3:0 select pull range, factory reset, host writable.
// RULE12 - Range codes 0000, 0001, 0010 define no range.
// RULE13 - Code 0011 is 25 ppm, code 0100 is 50 ppm.
// RULE14 - Code 0111 is 125, 1100 is 150, 1001 is 200 ppm.
// RULE15 - Code 1010 is 400, 1011 is 600, 1101 is 1200 ppm.
// RULE16 - Codes 0101, 0110, 1000, 1110, 1111 are reserved, no range.
// RULE17 - Divider bits 15:11 hold integer part, factory reset, host writable.
// RULE18 - Divider bits 10:0 hold upper fraction bits, factory reset, writable.
`timescale 1ns/100ps
`include "osc_freq_defs.svh"

module osc_freq_control_regs
  import osc_freq_pkg::*;
#(
  parameter range_code_t                 RANGE_DEFAULT   = `RANGE_RESET,
  parameter logic [`FB_INT_W-1:0]        FB_INT_DEFAULT  = `FB_INT_RESET,
  parameter logic [`FB_FRAC_HI_W-1:0]    FB_FRAC_DEFAULT = `FB_FRAC_HI_RESET
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  input  wire logic [`ADDR_W-1:0]        addr,
  input  wire logic [`DATA_W-1:0]        wdata,
  input  wire logic                      sw_oe_mode,
  input  wire logic                      oe_pin,
  output logic      [`DATA_W-1:0]        rdata_q,
  output logic                           drv_en_q,
  output pull_word_t                     pull_word_q,
  output logic                           pull_load_q,
  output range_code_t                    range_sel_q,
  output ppm_t                           range_ppm_q,
  output logic                           range_valid_q,
  output logic      [`FB_INT_W-1:0]      fb_div_int_q,
  output logic      [`FB_FRAC_HI_W-1:0]  fb_div_frac_hi_q
);

  function automatic logic addr_hit(
    input logic [`ADDR_W-1:0] a,
    input logic [`ADDR_W-1:0] ofs
  );
    return (a == ofs);
  endfunction : addr_hit

  localparam regs_t REG_RESET = '{
    pull_lower: `PULL_LOWER_RESET,
    pull_upper: `PULL_UPPER_RESET,
    oe_sw:      `OE_RESET,
    pull_word:  `PULL_WORD_RESET,
    pull_load:  1'b0,
    drv_en:     1'b0,
    range_sel:  RANGE_DEFAULT,
    range:      decode_range(RANGE_DEFAULT),
    fb_int:     FB_INT_DEFAULT,
    fb_frac_hi: FB_FRAC_DEFAULT,
    rdata:      '0
  };

  logic        rst_n_sync;
  logic        wr_lower;
  logic        wr_upper;
  logic        wr_range;
  logic        wr_div;
  logic        rd_go;
  logic        oe_nxt;
  range_code_t range_nxt;
  regs_t       q;
  regs_t       d;

  osc_rst_sync u_rst_sync (
    .clock        (clock),
    .rstn         (rstn),
    .rst_n_sync_q (rst_n_sync)
  );

  assign wr_lower = ce & wr_en & addr_hit(addr, `OFS_PULL_LOWER);
  assign wr_upper = ce & wr_en & addr_hit(addr, `OFS_OE_PULL_UPPER);
  assign wr_range = ce & wr_en & addr_hit(addr, `OFS_RANGE_SEL);
  assign wr_div   = ce & wr_en & addr_hit(addr, `OFS_FB_DIV);
  assign rd_go    = ce & rd_en;

  assign oe_nxt    = wr_upper ? wdata[`OE_BIT] : q.oe_sw;             // see RULE2
  assign range_nxt = wr_range ? wdata[`RANGE_MSB:0] : q.range_sel;    // see RULE11

  always_comb begin
    d           = q;
    d.pull_load = 1'b0;
    if (wr_lower) begin
      // Staged only; the applied word moves on the upper write
      d.pull_lower = wdata;                                           // see RULE5
    end
    if (wr_upper) begin
      d.pull_upper = wdata[`PULL_UPPER_MSB:0];                        // see RULE4
      d.pull_word  = pull_word_t'({wdata[`PULL_UPPER_MSB:0],
                                   q.pull_lower});                    // see RULE7
      d.pull_load  = 1'b1;                                            // see RULE8
    end
    d.oe_sw     = oe_nxt;
    // Pin mode passes the pin through; the stored bit waits for software mode
    d.drv_en    = sw_oe_mode ? oe_nxt : oe_pin;                       // see RULE3
    d.range_sel = range_nxt;
    d.range     = decode_range(range_nxt);                            // see RULE16
    if (wr_div) begin
      d.fb_int     = wdata[`FB_INT_MSB:`FB_INT_LSB];                  // see RULE17
      d.fb_frac_hi = wdata[`FB_FRAC_HI_MSB:0];                        // see RULE18
    end
    if (rd_go) begin
      // Returns the contents before any write in the same cycle
      case (addr)
        `OFS_PULL_LOWER: begin
          d.rdata = q.pull_lower;
        end
        `OFS_OE_PULL_UPPER: begin
          d.rdata = {5'h00, q.oe_sw, q.pull_upper};                   // see RULE1
        end
        `OFS_RANGE_SEL: begin
          d.rdata = {12'h000, q.range_sel};                           // see RULE10
        end
        `OFS_FB_DIV: begin
          d.rdata = {q.fb_int, q.fb_frac_hi};
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  // Low clock enable freezes everything, a pending load pulse included
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      q <= REG_RESET;                                                 // see RULE6
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata_q          = q.rdata;
  assign drv_en_q         = q.drv_en;
  assign pull_word_q      = q.pull_word;
  assign pull_load_q      = q.pull_load;
  assign range_sel_q      = q.range_sel;
  assign range_ppm_q      = q.range.ppm;
  assign range_valid_q    = q.range.valid;
  assign fb_div_int_q     = q.fb_int;
  assign fb_div_frac_hi_q = q.fb_frac_hi;

  AST_UPPER_ZERO_BITS: // see RULE1
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr == `OFS_OE_PULL_UPPER
    |=> rdata_q[`UPPER_ZERO_MSB:`UPPER_ZERO_LSB] == 5'h00)
  else $error("upper pull register top bits not zero");

  AST_SW_ENABLE: // see RULE2
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_upper && sw_oe_mode
    |=> drv_en_q == $past(wdata[`OE_BIT]))
  else $error("software enable write not applied");

  AST_OE_READBACK: // see RULE2
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr == `OFS_OE_PULL_UPPER
    |-> ##1 rdata_q[`OE_BIT] == $past(q.oe_sw))
  else $error("enable bit readback wrong");

  AST_PIN_MODE: // see RULE3
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    ce && !sw_oe_mode
    |=> drv_en_q == $past(oe_pin))
  else $error("pin mode enable does not follow pin");

  AST_UPPER_LOAD: // see RULE4
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_upper
    |=> pull_word_q[`PULL_W-1:`PULL_LOWER_W] == $past(wdata[`PULL_UPPER_MSB:0])
        && pull_load_q)
  else $error("upper pull bits not applied");

  AST_LOWER_JOIN: // see RULE5
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_upper
    |=> pull_word_q[`PULL_LOWER_W-1:0] == $past(q.pull_lower))
  else $error("lower pull bits not joined");

  AST_LOWER_READBACK: // see RULE5
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_lower ##1 (rd_go && addr == `OFS_PULL_LOWER && !wr_lower)
    |=> rdata_q == $past(wdata, 2))
  else $error("lower word readback wrong");

  AST_SIGNED_WORD: // see RULE7
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_upper && wdata[`PULL_UPPER_MSB]
    |=> pull_word_q < 0)
  else $error("pull word not treated as signed");

  AST_HOLD_NO_UPPER: // see RULE8
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    !wr_upper
    |=> $stable(pull_word_q) && !(ce && pull_load_q) || !$past(ce))
  else $error("pull word moved without upper write");

  AST_LOWER_ALONE: // see RULE8
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_lower ##1 !wr_upper
    |=> pull_word_q == $past(pull_word_q, 2))
  else $error("lower write alone changed the pull");

  AST_LOAD_PULSE: // see RULE8
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    pull_load_q && ce && !wr_upper
    |=> !pull_load_q)
  else $error("load pulse longer than one cycle");

  AST_ORDERED_PAIR: // see RULE9
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_lower ##1 wr_upper
    |=> pull_word_q[`PULL_LOWER_W-1:0] == $past(wdata, 2))
  else $error("ordered pair not applied together");

  AST_RANGE_ZERO_BITS: // see RULE10
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr == `OFS_RANGE_SEL
    |=> rdata_q[`DATA_W-1:`RANGE_ZERO_LSB] == 12'h000)
  else $error("range register top bits not zero");

  AST_RANGE_WRITE: // see RULE11
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_range
    |=> range_sel_q == $past(wdata[`RANGE_MSB:0]))
  else $error("range select not written");

  AST_RANGE_UNUSED: // see RULE12
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q <= 4'h2
    |-> !range_valid_q && range_ppm_q == `PPM_NONE)
  else $error("unused range code gave a range");

  AST_RANGE_LOW: // see RULE13
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_range && wdata[`RANGE_MSB:0] == `CODE_50PPM
    |=> range_valid_q && range_ppm_q == `PPM_50)
  else $error("code 0100 not 50 ppm");

  AST_RANGE_25: // see RULE13
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_25PPM
    |-> range_valid_q && range_ppm_q == `PPM_25)
  else $error("code 0011 not 25 ppm");

  AST_RANGE_MID: // see RULE14
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_150PPM
    |-> range_valid_q && range_ppm_q == `PPM_150)
  else $error("code 1100 not 150 ppm");

  AST_RANGE_200: // see RULE14
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_200PPM
    |-> range_ppm_q == `PPM_200)
  else $error("code 1001 not 200 ppm");

  AST_RANGE_HIGH: // see RULE15
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_1200PPM
    |-> range_valid_q && range_ppm_q == `PPM_1200)
  else $error("code 1101 not 1200 ppm");

  AST_RANGE_600: // see RULE15
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_600PPM
    |-> range_ppm_q == `PPM_600)
  else $error("code 1011 not 600 ppm");

  AST_RANGE_RESERVED: // see RULE16
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == 4'h5 || range_sel_q == 4'h6 || range_sel_q == 4'h8
      || range_sel_q == 4'he || range_sel_q == 4'hf
    |-> !range_valid_q && range_ppm_q == `PPM_NONE)
  else $error("reserved range code gave a range");

  AST_DIV_INT: // see RULE17
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_div
    |=> fb_div_int_q == $past(wdata[`FB_INT_MSB:`FB_INT_LSB]))
  else $error("divider integer not written");

  AST_DIV_FRAC: // see RULE18
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_div ##1 (rd_go && addr == `OFS_FB_DIV && !wr_div)
    |=> rdata_q[`FB_FRAC_HI_MSB:0] == $past(wdata[`FB_FRAC_HI_MSB:0], 2))
  else $error("divider fraction readback wrong");

  AST_UNMAPPED: // see RULE10
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr > `OFS_FB_DIV
    |=> rdata_q == '0)
  else $error("unmapped read not zero");

  AST_UPPER_READ: // see RULE4
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr == `OFS_OE_PULL_UPPER
    |=> rdata_q[`PULL_UPPER_MSB:0] == $past(q.pull_upper))
  else $error("upper pull bits readback wrong");

  AST_RANGE_READ: // see RULE11
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr == `OFS_RANGE_SEL
    |=> rdata_q[`RANGE_MSB:0] == $past(q.range_sel))
  else $error("range code readback wrong");

  AST_RANGE_125: // see RULE14
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_125PPM
    |-> range_valid_q && range_ppm_q == `PPM_125)
  else $error("code 0111 not 125 ppm");

  AST_RANGE_400: // see RULE15
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    range_sel_q == `CODE_400PPM
    |-> range_valid_q && range_ppm_q == `PPM_400)
  else $error("code 1010 not 400 ppm");

  AST_DIV_READ: // see RULE17
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    rd_go && addr == `OFS_FB_DIV
    |=> rdata_q[`FB_INT_MSB:`FB_INT_LSB] == $past(q.fb_int)
        && rdata_q[`FB_FRAC_HI_MSB:0] == $past(q.fb_frac_hi))
  else $error("divider readback wrong");

  AST_DIV_FRAC_WRITE: // see RULE18
  assert property (@(posedge clock) disable iff (!rst_n_sync)
    wr_div
    |=> fb_div_frac_hi_q == $past(wdata[`FB_FRAC_HI_MSB:0]))
  else $error("divider fraction not written");

endmodule : osc_freq_control_regs

/* hw/osc_freq_defs.svh */
// Offsets, field positions, reset values and pull range codes
// of the oscillator frequency control registers.
// Included by the package and by the register bank.
`ifndef OSC_FREQ_DEFS_SVH
`define OSC_FREQ_DEFS_SVH

`define ADDR_W             8
`define DATA_W             16

`define OFS_PULL_LOWER     8'h00
`define OFS_OE_PULL_UPPER  8'h01
`define OFS_RANGE_SEL      8'h02
`define OFS_FB_DIV         8'h03

`define OE_BIT             10
`define PULL_UPPER_MSB     9
`define PULL_UPPER_W       10
`define PULL_LOWER_W       16
`define PULL_W             26
`define UPPER_ZERO_MSB     15
`define UPPER_ZERO_LSB     11
`define RANGE_MSB          3
`define RANGE_W            4
`define RANGE_ZERO_LSB     4
`define FB_INT_MSB         15
`define FB_INT_LSB         11
`define FB_INT_W           5
`define FB_FRAC_HI_MSB     10
`define FB_FRAC_HI_W       11
`define PPM_W              11

`define PULL_LOWER_RESET   16'h0000
`define PULL_UPPER_RESET   10'h000
`define PULL_WORD_RESET    26'h0000000
`define OE_RESET           1'b0
`define RANGE_RESET        4'h3
`define FB_INT_RESET       5'h00
`define FB_FRAC_HI_RESET   11'h000

`define CODE_25PPM         4'h3
`define CODE_50PPM         4'h4
`define CODE_125PPM        4'h7
`define CODE_150PPM        4'hc
`define CODE_200PPM        4'h9
`define CODE_400PPM        4'ha
`define CODE_600PPM        4'hb
`define CODE_1200PPM       4'hd

// Half range in ppm
`define PPM_NONE           11'h000
`define PPM_25             11'h019
`define PPM_50             11'h032
`define PPM_125            11'h07d
`define PPM_150            11'h096
`define PPM_200            11'h0c8
`define PPM_400            11'h190
`define PPM_600            11'h258
`define PPM_1200           11'h4b0

`endif

/* hw/osc_freq_pkg.sv */
// Types and the pull range decode of the frequency control registers.
// Needs osc_freq_defs.svh on the include path.
`include "osc_freq_defs.svh"

package osc_freq_pkg;

  typedef logic [`RANGE_W-1:0]       range_code_t;
  typedef logic [`PPM_W-1:0]         ppm_t;
  typedef logic signed [`PULL_W-1:0] pull_word_t;

  typedef struct packed {
    logic valid;
    ppm_t ppm;
  } range_info_t;

  typedef struct packed {
    logic                       pull_lower_dummy_unused_never;
  } unused_t;

  typedef struct packed {
    logic [`PULL_LOWER_W-1:0]   pull_lower;
    logic [`PULL_UPPER_W-1:0]   pull_upper;
    logic                       oe_sw;
    pull_word_t                 pull_word;
    logic                       pull_load;
    logic                       drv_en;
    range_code_t                range_sel;
    range_info_t                range;
    logic [`FB_INT_W-1:0]       fb_int;
    logic [`FB_FRAC_HI_W-1:0]   fb_frac_hi;
    logic [`DATA_W-1:0]         rdata;
  } regs_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_t;

  // Ambiguous and unlisted codes count as reserved: no range
  function automatic range_info_t decode_range(input range_code_t code);
    range_info_t r;
    r = '{valid: 1'b1, ppm: `PPM_NONE};
    case (code)
      `CODE_25PPM:   r.ppm = `PPM_25;      // see RULE13
      `CODE_50PPM:   r.ppm = `PPM_50;      // see RULE13
      `CODE_125PPM:  r.ppm = `PPM_125;     // see RULE14
      `CODE_150PPM:  r.ppm = `PPM_150;     // see RULE14
      `CODE_200PPM:  r.ppm = `PPM_200;     // see RULE14
      `CODE_400PPM:  r.ppm = `PPM_400;     // see RULE15
      `CODE_600PPM:  r.ppm = `PPM_600;     // see RULE15
      `CODE_1200PPM: r.ppm = `PPM_1200;    // see RULE15
      default:       r.valid = 1'b0;       // see RULE12 RULE16
    endcase
    return r;
  endfunction : decode_range

endpackage : osc_freq_pkg

/* hw/osc_rst_sync.sv */
// Reset release synchroniser for the frequency control registers.
// Assert is asynchronous, release follows two clock edges.
`timescale 1ns/100ps

module osc_rst_sync
  import osc_freq_pkg::*;
(
  input  wire logic clock,
  input  wire logic rstn,
  output logic      rst_n_sync_q
);

  sync_t q;
  sync_t d;

  // First stage feeds only the second
  always_comb begin
    d        = q;
    d.stage1 = 1'b1;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rst_n_sync_q = q.stage2;

endmodule : osc_rst_sync

/* verif/osc_host.sv */
// Host model of the register port: word writes, word reads, idle.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/100ps
`include "osc_freq_defs.svh"

module osc_host (
  input  wire logic               clock,
  input  wire logic [`DATA_W-1:0] rdata_q,
  output logic                    wr_en,
  output logic                    rd_en,
  output logic      [`ADDR_W-1:0] addr,
  output logic      [`DATA_W-1:0] wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 16'h0000;
  end

  // Strobe stays up on return so back-to-back calls need no gap
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    wr_en = 1'b1;
    rd_en = 1'b0;
    addr  = a;
    wdata = d;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
    wr_en = 1'b0;
    rd_en = 1'b1;
    addr  = a;
    @(negedge clock);
    d = rdata_q;
  endtask : rd

  // Released lines flip so a stale value never passes as valid
  task automatic idle();
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = ~addr;
    wdata = ~wdata;
    @(negedge clock);
  endtask : idle

  task automatic wr_pull(input logic [`DATA_W-1:0] lo, input logic [`DATA_W-1:0] hi);
    wr(`OFS_PULL_LOWER, lo);
    wr(`OFS_OE_PULL_UPPER, hi);
  endtask : wr_pull
endmodule : osc_host

/* verif/test_osc_freq_control_regs.sv */
// Self-checking bench of the frequency control register bank.
// Drives inputs at the falling edge; the host model owns the register port.
`timescale 1ns/100ps
`include "osc_freq_defs.svh"

module test_osc_freq_control_regs;
  import osc_freq_pkg::*;

  localparam range_code_t              RANGE_DEF = 4'hd;
  localparam logic [`FB_INT_W-1:0]     INT_DEF   = 5'h15;
  localparam logic [`FB_FRAC_HI_W-1:0] FRAC_DEF  = 11'h2a5;

  logic                      clock = 1'b0;
  logic                      rstn;
  logic                      ce;
  logic                      sw_oe_mode;
  logic                      oe_pin;
  logic                      wr_en;
  logic                      rd_en;
  logic [`ADDR_W-1:0]        addr;
  logic [`DATA_W-1:0]        wdata;
  logic [`DATA_W-1:0]        rdata_q;
  logic                      drv_en_q;
  pull_word_t                pull_word_q;
  logic                      pull_load_q;
  range_code_t               range_sel_q;
  ppm_t                      range_ppm_q;
  logic                      range_valid_q;
  logic [`FB_INT_W-1:0]      fb_div_int_q;
  logic [`FB_FRAC_HI_W-1:0]  fb_div_frac_hi_q;
  int                        failures = 0;
  int                        cmp_count = 0;
  logic [15:0]               u;
  logic [15:0]               l;
  logic [15:0]               v;
  logic [7:0]                a;
  pull_word_t                pw;
  range_info_t               ri;

  always #2.5 clock = ~clock;

  osc_freq_control_regs #(
    .RANGE_DEFAULT   (RANGE_DEF),
    .FB_INT_DEFAULT  (INT_DEF),
    .FB_FRAC_DEFAULT (FRAC_DEF)
  ) osc_freq_control_regs_inst (
    .clock            (clock),
    .rstn             (rstn),
    .ce               (ce),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .addr             (addr),
    .wdata            (wdata),
    .sw_oe_mode       (sw_oe_mode),
    .oe_pin           (oe_pin),
    .rdata_q          (rdata_q),
    .drv_en_q         (drv_en_q),
    .pull_word_q      (pull_word_q),
    .pull_load_q      (pull_load_q),
    .range_sel_q      (range_sel_q),
    .range_ppm_q      (range_ppm_q),
    .range_valid_q    (range_valid_q),
    .fb_div_int_q     (fb_div_int_q),
    .fb_div_frac_hi_q (fb_div_frac_hi_q)
  );

  osc_host osc_host_inst (
    .clock   (clock),
    .rdata_q (rdata_q),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .addr    (addr),
    .wdata   (wdata)
  );

  function automatic range_info_t exp_range(input range_code_t c);
    case (c)
      4'h3:    return '{1'b1, `PPM_25};
      4'h4:    return '{1'b1, `PPM_50};
      4'h7:    return '{1'b1, `PPM_125};
      4'hc:    return '{1'b1, `PPM_150};
      4'h9:    return '{1'b1, `PPM_200};
      4'ha:    return '{1'b1, `PPM_400};
      4'hb:    return '{1'b1, `PPM_600};
      4'hd:    return '{1'b1, `PPM_1200};
      default: return '{1'b0, `PPM_NONE};
    endcase
  endfunction : exp_range

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic rd_chk(input string n, input logic [7:0] ra, input logic [15:0] e);
    logic [15:0] d;
    osc_host_inst.rd(ra, d);
    check(n, e, d);
  endtask : rd_chk

  // Run takes well under a thousand cycles
  initial begin
    #50000;
    failures++;
    give_verdict();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    sw_oe_mode = 1'b1;
    oe_pin = 1'b0;
    void'($urandom(32));
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    ri = exp_range(RANGE_DEF);
    check("drv_en", 0, drv_en_q);
    check("pull_word", 0, pull_word_q);
    check("range_ppm", ri.ppm, range_ppm_q);
    rd_chk("lower", `OFS_PULL_LOWER, 16'h0000);
    rd_chk("upper", `OFS_OE_PULL_UPPER, 16'h0000);
    rd_chk("range", `OFS_RANGE_SEL, {12'h000, RANGE_DEF});
    rd_chk("div", `OFS_FB_DIV, {INT_DEF, FRAC_DEF});
    osc_host_inst.wr(`OFS_RANGE_SEL, 16'hfff0);
    rd_chk("range", `OFS_RANGE_SEL, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      l = $urandom;
      u = $urandom;
      case (i)
        0: begin l = 16'h0000; u = 16'hfa00; end
        1: begin l = 16'hffff; u = 16'h07ff; end
        2: begin l = 16'hffff; u = 16'h01ff; end
        default: ;
      endcase
      osc_host_inst.wr_pull(l, u);
      pw = pull_word_t'({u[9:0], l});
      check("pull_word", pw, pull_word_q);
      check("pull_load", 1, pull_load_q);
      check("pull_sign", u[9], pull_word_q < 0);
      check("drv_en", u[10], drv_en_q);
      osc_host_inst.wr(`OFS_PULL_LOWER, ~l);
      check("pull_load", 0, pull_load_q);
      rd_chk("lower", `OFS_PULL_LOWER, ~l);
      osc_host_inst.idle();
      check("pull_word", pw, pull_word_q);
      rd_chk("upper", `OFS_OE_PULL_UPPER, u & 16'h07ff);
    end
    sw_oe_mode = 1'b0;
    for (int i = 0; i < 8; i++) begin
      oe_pin = $urandom;
      osc_host_inst.wr(`OFS_OE_PULL_UPPER, {5'h1f, ~oe_pin, 10'h155});
      check("drv_en_pin", oe_pin, drv_en_q);
    end
    sw_oe_mode = 1'b1;
    osc_host_inst.idle();
    check("drv_en_sw", !oe_pin, drv_en_q);
    for (int k = 0; k < 16; k++) begin
      v = $urandom;
      ri = exp_range(k[3:0]);
      osc_host_inst.wr(`OFS_RANGE_SEL, {v[15:4], k[3:0]});
      check("range_sel", k[3:0], range_sel_q);
      check("range_valid", ri.valid, range_valid_q);
      check("range_ppm", ri.ppm, range_ppm_q);
      rd_chk("range", `OFS_RANGE_SEL, {12'h000, k[3:0]});
    end
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      a = 8'h04 + 8'($urandom % 252);
      osc_host_inst.wr(`OFS_FB_DIV, v);
      check("fb_int", v[15:11], fb_div_int_q);
      check("fb_frac", v[10:0], fb_div_frac_hi_q);
      rd_chk("div", `OFS_FB_DIV, v);
      osc_host_inst.wr(a, ~v);
      rd_chk("unmapped", a, 16'h0000);
      rd_chk("div", `OFS_FB_DIV, v);
    end
    ce = 1'b0;
    osc_host_inst.wr(`OFS_FB_DIV, ~v);
    osc_host_inst.idle();
    ce = 1'b1;
    rd_chk("div_frozen", `OFS_FB_DIV, v);
    osc_host_inst.idle();
    give_verdict();
  end
endmodule : test_osc_freq_control_regs
